// ==== sim/lcdci_asserts.sv ====
// Port checker for the display command interpreter.
// Assumes binding to lcdci_top; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module lcdci_asserts #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              host_wr,
  input wire logic              host_cmd,
  input wire logic [DATA_W-1:0] host_data,
  input wire logic [ADDR_W-1:0] line_pitch,
  input wire logic              host_ready,
  input wire logic              mem_wr_valid,
  input wire logic              mem_wr_ready,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic [DATA_W-1:0] mem_data,
  input wire logic [7:0]        display_enable,
  input wire logic [7:0]        display_attribute,
  input wire logic [7:0]        cursor_width,
  input wire logic [7:0]        cursor_height_shape,
  input wire logic [7:0]        cursor_shift_direction,
  input wire logic [7:0]        cursor_address_low,
  input wire logic [7:0]        cursor_address_high
);
  // Taken bytes, expected field images and the cursor step
  wire        tk  = host_wr && host_ready;
  wire        tc  = tk && host_cmd;
  wire        tp  = tk && !host_cmd;
  wire [15:0] cur = {cursor_address_high, cursor_address_low};
  wire [7:0]  wd  = {4'h0, host_data[3:0]};
  wire [7:0]  hs  = {host_data[7], 3'h0, host_data[3:0]};
  wire [7:0]  dr  = {6'h00, host_data[1:0]};
  wire [1:0]  d   = cursor_shift_direction[1:0];
  wire [15:0] stp = (d == 2'h0) ? 16'h0001 : (d == 2'h1) ? 16'hFFFF :
                    (d == 2'h2) ? (16'h0000 - line_pitch) : line_pitch;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // ****************************************
  // Assertions
  // ****************************************
  disp_off_a: assert property (tc && host_data == 8'h58 |=> display_enable == 8'h00)
    else $error("display not blanked");
  disp_on_a: assert property (tc && host_data == 8'h59 |=> display_enable == 8'h01)
    else $error("display not on");
  attr_store_a: assert property (tc && host_data[7:1] == 7'h2C ##1 tp |=>
    display_attribute == $past(host_data)) else $error("attribute not stored");
  addr_pair_a: assert property (tc && host_data == 8'h46 ##1 tp ##1 tp |=>
    cur == {$past(host_data), $past(host_data, 2)}) else $error("cursor pair wrong");
  width_store_a: assert property (tc && host_data == 8'h5D ##1 tp |=>
    cursor_width == $past(wd)) else $error("width wrong");
  height_shape_a: assert property (tc && host_data == 8'h5D ##1 tp ##1 tp |=>
    cursor_height_shape == $past(hs)) else $error("height or shape wrong");
  dir_code_a: assert property (tc && host_data[7:2] == 6'h13 |=>
    cursor_shift_direction == $past(dr)) else $error("direction wrong");
  mem_word_a: assert property (tc && host_data == 8'h42 ##1 tp && !mem_wr_valid |=>
    mem_wr_valid && mem_data == $past(host_data) && mem_addr == $past(cur))
    else $error("memory word wrong");
  cursor_step_a: assert property (tc && host_data == 8'h42 ##1 tp |=>
    cur == $past(cur) + $past(stp)) else $error("cursor step wrong");
  word_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
    mem_wr_valid && $stable(mem_addr) && $stable(mem_data)) else $error("word dropped");
  refused_byte_a: assert property (host_wr && !host_ready |=>
    $stable(display_enable) && $stable(cur)) else $error("refused byte acted");
endmodule : lcdci_asserts

// ==== sim/lcdci_sink.sv ====
// Display memory side model: takes write words, can stall on request.
// Assumes the bench drives stall away from the rising edge.
`timescale 1ns/1ps
module lcdci_sink (
  input  wire logic        sys_clk,
  input  wire logic        stall,
  input  wire logic        mem_wr_valid,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_data,
  output logic             mem_wr_ready
);
  logic [23:0] got_q[$];
  // Ready moves just after the rising edge, from the stall level set earlier
  initial mem_wr_ready = 1'b0;
  always @(posedge sys_clk) begin
    mem_wr_ready <= !stall;
  end
  // A word counts only where valid meets ready
  always @(posedge sys_clk) begin
    if (mem_wr_valid && mem_wr_ready) begin
      got_q.push_back({mem_addr, mem_data});
    end
  end
endmodule : lcdci_sink

// ==== sim/tb.sv ====
// Bench for the display command interpreter: host bytes in, words out.
// Assumes lcdci_top, the sink model and the checker are compiled first.
`timescale 1ns/1ps
module tb;
  logic        sys_clk, rst_b, host_wr, host_cmd, stall, host_ready, mem_wr_valid, mem_wr_ready;
  logic [7:0]  host_data, mem_data, display_enable, display_attribute, cursor_width;
  logic [7:0]  cursor_height_shape, cursor_shift_direction, cursor_address_low;
  logic [7:0]  cursor_address_high;
  logic [15:0] line_pitch, mem_addr;
  logic [23:0] exp_q[$];
  int          fails, cmp_count, cyc;
  lcdci_top dut (.*);
  lcdci_sink snk (.*);
  // Clock and a hang limit far above the fewer than a hundred cycles needed
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task results;
    $display("Counts: fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  task chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Byte offered at a falling edge; waits out a full buffer, bounded
  task put(input logic c, input logic [7:0] dat);
    int n;
    n = 0;
    while (host_ready !== 1'b1 && n < 40) begin
      host_wr = 1'b0;
      n++;
      @(negedge sys_clk);
    end
    if (n == 40) fails++;
    host_wr = 1'b1;
    host_cmd = c;
    host_data = dat;
    @(negedge sys_clk);
  endtask : put
  task putn(input logic [7:0] dat, input int k);
    repeat (k) put(1'b0, dat);
  endtask : putn
  task settle;
    host_wr = 1'b0;
    @(negedge sys_clk);
  endtask : settle
  task expw(input logic [15:0] a, input logic [15:0] s, input logic [7:0] dat, input int k);
    for (int i = 0; i < k; i++) exp_q.push_back({a + s * 16'(i), dat});
  endtask : expw
  // Waits for the sink to catch up, then compares word by word
  task drain;
    int n;
    n = 0;
    while (snk.got_q.size() < exp_q.size() && n < 100) begin
      n++;
      @(negedge sys_clk);
    end
    chk(24'(snk.got_q.size()), 24'(exp_q.size()));
    foreach (exp_q[i]) chk(snk.got_q[i], exp_q[i]);
    exp_q.delete();
    snk.got_q.delete();
  endtask : drain
  // ****************************************
  // Scenarios
  // ****************************************
  task t_disp;
    chk({display_enable, 7'h00, host_ready, 7'h00, mem_wr_valid}, 24'h000100);
    put(1'b1, 8'h59);
    put(1'b0, 8'h16);
    settle();
    chk({display_enable, display_attribute, 8'h00}, 24'h011600);
  endtask : t_disp
  // Host order: off, clear both layers, cursor setup, then on
  task t_init;
    put(1'b1, 8'h58);
    put(1'b0, 8'h56);
    settle();
    chk({display_enable, display_attribute, 8'h00}, 24'h005600);
    put(1'b1, 8'h46);
    putn(8'h00, 2);
    put(1'b1, 8'h4C);
    put(1'b1, 8'h42);
    putn(8'h20, 3);
    expw(16'h0000, 16'h0001, 8'h20, 3);
    put(1'b1, 8'h46);
    put(1'b0, 8'h00);
    put(1'b0, 8'h10);
    put(1'b1, 8'h42);
    putn(8'h00, 2);
    expw(16'h1000, 16'h0001, 8'h00, 2);
    put(1'b1, 8'h5D);
    put(1'b0, 8'h04);
    put(1'b0, 8'h86);
    put(1'b1, 8'h59);
    settle();
    chk({cursor_width, cursor_height_shape, display_enable}, 24'h048601);
    drain();
  endtask : t_init
  task t_dir;
    for (int i = 0; i < 4; i++) begin
      put(1'b1, {6'h13, 2'(i)});
      settle();
      chk({16'h0000, cursor_shift_direction}, 24'(i));
    end
  endtask : t_dir
  // Vertical column with a stalled sink, a refused byte, then release
  task t_col;
    put(1'b1, 8'h46);
    put(1'b0, 8'h01);
    put(1'b0, 8'h10);
    settle();
    chk({8'h00, cursor_address_high, cursor_address_low}, 24'h001001);
    put(1'b1, 8'h4F);
    stall = 1'b1;
    put(1'b1, 8'h42);
    putn(8'hFF, 2);
    settle();
    settle();
    chk({23'h000000, host_ready}, 24'h000000);
    host_wr = 1'b1;
    host_cmd = 1'b1;
    host_data = 8'h58;
    @(negedge sys_clk);
    settle();
    chk({16'h0000, display_enable}, 24'h000001);
    stall = 1'b0;
    putn(8'hFF, 7);
    settle();
    expw(16'h1001, line_pitch, 8'hFF, 9);
    drain();
    chk({8'h00, cursor_address_high, cursor_address_low}, 24'h001169);
  endtask : t_col
  // Reset held for eight edges, then the scenarios in turn
  initial begin
    sys_clk = 1'b0;
    {rst_b, host_wr, host_cmd, stall} = 4'h0;
    host_data = 8'h00;
    line_pitch = 16'h0028;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (8) @(negedge sys_clk);
    rst_b = 1'b1;
    t_disp();
    t_init();
    t_dir();
    t_col();
    results();
  end
endmodule : tb
bind lcdci_top lcdci_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) chk_i (.*);

// ==== src/lcdci_buf.sv ====
// Two-entry write buffer, head always in slot 0 so outputs are flops.
// Assumes a synchronous active-low reset on the single system clock.
`timescale 1ns/1ps
module lcdci_buf #(
  parameter int WIDTH = 24
) (
  input  wire logic      sys_clk,
  input  wire logic      rst_b,
  lcdci_buf_if.buffer    bus
);

  logic [WIDTH-1:0] slot0;
  logic [WIDTH-1:0] slot1;
  logic [1:0]       count;
  logic             ready_q;
  logic             valid_q;
  wire              push;
  wire              pop;
  wire  [1:0]       next_count;

  // Handshakes and occupancy
  assign push = bus.in_valid && ready_q;
  assign pop  = valid_q && bus.out_ready;
  assign next_count = count + {1'b0, push} - {1'b0, pop};
  assign bus.in_ready  = ready_q;
  assign bus.out_valid = valid_q;
  assign bus.out_data  = slot0;

  // ********************************************************
  // Storage
  // ********************************************************
  // Ready is registered from next count, so a stall backs up to the host
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count   <= 2'h0;
      ready_q <= 1'b1;
      valid_q <= 1'b0;
      slot0   <= '0;
      slot1   <= '0;
    end else begin
      count   <= next_count;
      ready_q <= (next_count != 2'h2);
      valid_q <= (next_count != 2'h0);
      case ({push, pop})
        2'b10: begin
          if (count == 2'h0) slot0 <= bus.in_data;
          else slot1 <= bus.in_data;
        end
        2'b01: slot0 <= slot1;
        2'b11: begin
          if (count == 2'h1) slot0 <= bus.in_data;
          else begin
            slot0 <= slot1;
            slot1 <= bus.in_data;
          end
        end
        default: ;
      endcase
    end
  end

endmodule : lcdci_buf

// ==== src/lcdci_buf_if.sv ====
// Valid/ready carrier between the command parser and its write buffer.
// Assumes one clock shared by both sides.
`timescale 1ns/1ps
interface lcdci_buf_if #(parameter int WIDTH = 24);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  modport producer (output in_valid, output in_data, input in_ready,
                    input out_valid, input out_data, output out_ready);
  modport buffer   (input in_valid, input in_data, output in_ready,
                    output out_valid, output out_data, input out_ready);
endinterface : lcdci_buf_if

// ==== src/lcdci_defines.svh ====
// Constants of the display command interpreter: command codes,
// register offsets, field positions and reset values.
// Assumes inclusion by bare name from lcdci_top.
`ifndef LCDCI_DEFINES_SVH
`define LCDCI_DEFINES_SVH

// ********************************************************
// Command codes
// ********************************************************
`define LCDCI_CMD_DISP_OFF   8'h58
`define LCDCI_CMD_DISP_ON    8'h59
`define LCDCI_CMD_CSR_ADDR   8'h46
`define LCDCI_CMD_CURSOR_SHAPE_CMD   8'h5D
`define LCDCI_CMD_DIR_BASE   6'h13
`define LCDCI_CMD_MEM_WRITE  8'h42

// ********************************************************
// Register offsets (kept for reference; neither the bench nor any module uses them)
// ********************************************************
`define LCDCI_REG_DISPLAY_ENABLE    8'h09
`define LCDCI_REG_DISPLAY_ATTRIBUTE 8'h0A
`define LCDCI_REG_CURSOR_WIDTH      8'h15
`define LCDCI_REG_CURSOR_HEIGHT     8'h16
`define LCDCI_REG_CURSOR_DIR        8'h17
`define LCDCI_REG_CURSOR_ADDR_LOW   8'h1C
`define LCDCI_REG_CURSOR_ADDR_HIGH  8'h1D

// ********************************************************
// Field positions
// ********************************************************
`define LCDCI_DISPLAY_ON_BIT   0
`define LCDCI_SIZE_MSB         3
`define LCDCI_SHAPE_BIT        7

// ********************************************************
// Reset values
// ********************************************************
`define LCDCI_RST_BYTE   8'h00
`define LCDCI_RST_ADDR   16'h0000

`endif

// ==== src/lcdci_pkg.sv ====
// Types of the display command interpreter, used by lcdci_top alone.
// Assumes nothing of its surroundings.
package lcdci_pkg;

  // ********************************************************
  // Parser states and shift directions
  // ********************************************************
  typedef enum logic [2:0] {
    LCDCI_IDLE,
    LCDCI_DISP_P1,
    LCDCI_ADDR_P1,
    LCDCI_ADDR_P2,
    LCDCI_FORM_P1,
    LCDCI_FORM_P2,
    LCDCI_MEMORY_WRITE_CMD
  } lcdci_state_type;

  typedef enum logic [1:0] {
    LCDCI_RIGHT,
    LCDCI_LEFT,
    LCDCI_UP,
    LCDCI_DOWN
  } lcdci_dir_type;

endpackage : lcdci_pkg

// ==== src/lcdci_top.sv ====
// Command interpreter of a graphics display controller: the host writes
// command and parameter bytes; memory writes leave through a buffer.
// Assumes host inputs synchronous to sys_clk and a single-cycle write strobe.
// Registers leave as outputs only; there is no read-back path.
`timescale 1ns/1ps
`include "lcdci_defines.svh"

module lcdci_top #(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              host_wr,
  input  wire logic              host_cmd,
  input  wire logic [DATA_W-1:0] host_data,
  input  wire logic [ADDR_W-1:0] line_pitch,
  output logic                   host_ready,
  output logic                   mem_wr_valid,
  input  wire logic              mem_wr_ready,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_data,
  output logic [7:0]             display_enable,
  output logic [7:0]             display_attribute,
  output logic [7:0]             cursor_width,
  output logic [7:0]             cursor_height_shape,
  output logic [7:0]             cursor_shift_direction,
  output logic [7:0]             cursor_address_low,
  output logic [7:0]             cursor_address_high
);

  // ********************************************************
  // Helpers
  // ********************************************************
  // Next cursor position after one memory byte; wraps at address width
  function automatic logic [ADDR_W-1:0] lcdci_advance(
    input logic [ADDR_W-1:0] addr,
    input logic [1:0]        dir,
    input logic [ADDR_W-1:0] pitch
  );
    logic [ADDR_W-1:0] res;
    res = addr;
    case (dir)
      lcdci_pkg::LCDCI_RIGHT: res = addr + ADDR_W'(1);
      lcdci_pkg::LCDCI_LEFT:  res = addr - ADDR_W'(1);
      lcdci_pkg::LCDCI_UP:    res = addr - pitch;
      lcdci_pkg::LCDCI_DOWN:  res = addr + pitch;
      default:                res = addr;
    endcase
    return res;
  endfunction : lcdci_advance

  // Low nibble of a size byte; upper bits cleared so the field reads clean
  function automatic logic [7:0] lcdci_size_field(
    input logic [7:0] b
  );
    return {4'h0, b[`LCDCI_SIZE_MSB:0]};
  endfunction : lcdci_size_field

  // ********************************************************
  // Buffer in the memory write path
  // ********************************************************
  // Two words of slack let the sink stall without losing a host byte
  lcdci_buf_if #(.WIDTH(ADDR_W + DATA_W)) bif ();

  lcdci_buf #(
    .WIDTH (ADDR_W + DATA_W)
  ) u_buf (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .bus     (bif.buffer)
  );

  lcdci_pkg::lcdci_state_type state;
  lcdci_pkg::lcdci_state_type next_state;
  wire                        taken;
  wire                        cmd_taken;
  wire                        par_taken;
  wire                        is_dir_cmd;
  wire  [ADDR_W-1:0]          cursor_addr;
  wire  [ADDR_W-1:0]          next_cursor_addr;
  wire                        mem_push;
  wire                        disp_off_cmd;
  wire                        disp_on_cmd;
  wire                        disp_par;
  wire                        addr_lo_par;
  wire                        addr_hi_par;
  wire                        width_par;
  wire                        height_par;

  // Byte acceptance; writes while not ready are ignored by design
  assign taken      = host_wr && bif.in_ready;
  assign cmd_taken  = taken && host_cmd;
  assign par_taken  = taken && !host_cmd;
  assign is_dir_cmd = (host_data[7:2] == `LCDCI_CMD_DIR_BASE);
  assign cursor_addr = ADDR_W'({cursor_address_high, cursor_address_low});
  assign mem_push   = par_taken && (state == lcdci_pkg::LCDCI_MEMORY_WRITE_CMD);
  assign next_cursor_addr = lcdci_advance(cursor_addr, cursor_shift_direction[1:0],
                                          line_pitch);

  // ********************************************************
  // Command and parameter decode
  // ********************************************************
  // On/off codes act at once; their attribute byte follows as a parameter
  assign disp_off_cmd = cmd_taken && (host_data == `LCDCI_CMD_DISP_OFF);
  assign disp_on_cmd  = cmd_taken && (host_data == `LCDCI_CMD_DISP_ON);

  // Parameter slots; a byte with no open slot changes nothing
  assign disp_par    = par_taken && (state == lcdci_pkg::LCDCI_DISP_P1);
  assign addr_lo_par = par_taken && (state == lcdci_pkg::LCDCI_ADDR_P1);
  assign addr_hi_par = par_taken && (state == lcdci_pkg::LCDCI_ADDR_P2);
  assign width_par   = par_taken && (state == lcdci_pkg::LCDCI_FORM_P1);
  assign height_par  = par_taken && (state == lcdci_pkg::LCDCI_FORM_P2);

  // Buffer connections; memory word is cursor address above data byte
  assign bif.in_valid  = mem_push;
  assign bif.in_data   = {cursor_addr, host_data};
  assign bif.out_ready = mem_wr_ready;
  assign host_ready    = bif.in_ready;
  assign mem_wr_valid  = bif.out_valid;
  assign mem_addr      = bif.out_data[ADDR_W+DATA_W-1:DATA_W];
  assign mem_data      = bif.out_data[DATA_W-1:0];

  // ********************************************************
  // Command decoder
  // ********************************************************
  // A new command always aborts any parameter sequence in progress
  always_comb begin
    next_state = state;
    if (cmd_taken) begin
      case (host_data)
        `LCDCI_CMD_DISP_OFF,
        `LCDCI_CMD_DISP_ON:   next_state = lcdci_pkg::LCDCI_DISP_P1;
        `LCDCI_CMD_CSR_ADDR:  next_state = lcdci_pkg::LCDCI_ADDR_P1;
        `LCDCI_CMD_CURSOR_SHAPE_CMD:  next_state = lcdci_pkg::LCDCI_FORM_P1;
        `LCDCI_CMD_MEM_WRITE: next_state = lcdci_pkg::LCDCI_MEMORY_WRITE_CMD;
        default:              next_state = lcdci_pkg::LCDCI_IDLE;
      endcase
    end else if (par_taken) begin
      case (state)
        lcdci_pkg::LCDCI_DISP_P1: next_state = lcdci_pkg::LCDCI_IDLE;
        lcdci_pkg::LCDCI_ADDR_P1: next_state = lcdci_pkg::LCDCI_ADDR_P2;
        lcdci_pkg::LCDCI_ADDR_P2: next_state = lcdci_pkg::LCDCI_IDLE;
        lcdci_pkg::LCDCI_FORM_P1: next_state = lcdci_pkg::LCDCI_FORM_P2;
        lcdci_pkg::LCDCI_FORM_P2: next_state = lcdci_pkg::LCDCI_IDLE;
        lcdci_pkg::LCDCI_MEMORY_WRITE_CMD:  next_state = lcdci_pkg::LCDCI_MEMORY_WRITE_CMD;
        default:                  next_state = lcdci_pkg::LCDCI_IDLE;
      endcase
    end
  end

  // Parser state; reset leaves it idle so stray parameters are dropped
  always_ff @(posedge sys_clk) begin
    if (!rst_b) state <= lcdci_pkg::LCDCI_IDLE;
    else state <= next_state;
  end

  // ********************************************************
  // Register file
  // ********************************************************
  // Display enable follows the low bit of the on/off code
  always_ff @(posedge sys_clk) begin
    if (!rst_b) display_enable <= `LCDCI_RST_BYTE;
    else if (disp_off_cmd)
      display_enable[`LCDCI_DISPLAY_ON_BIT] <= 1'b0;
    else if (disp_on_cmd)
      display_enable[`LCDCI_DISPLAY_ON_BIT] <= 1'b1;
  end

  // Flash and block fields are kept whole; the panel logic decodes them
  always_ff @(posedge sys_clk) begin
    if (!rst_b) display_attribute <= `LCDCI_RST_BYTE;
    else if (disp_par)
      display_attribute <= host_data;
  end

  // Cursor size and shape; unused upper bits of width read as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cursor_width        <= `LCDCI_RST_BYTE;
      cursor_height_shape <= `LCDCI_RST_BYTE;
    end else if (width_par) begin
      cursor_width <= lcdci_size_field(host_data);
    end else if (height_par) begin
      cursor_height_shape <= lcdci_size_field(host_data) |
                             {host_data[`LCDCI_SHAPE_BIT], 7'h00};
    end
  end

  // Direction codes carry no parameters
  always_ff @(posedge sys_clk) begin
    if (!rst_b) cursor_shift_direction <= `LCDCI_RST_BYTE;
    else if (cmd_taken && is_dir_cmd)
      cursor_shift_direction <= {6'h00, host_data[1:0]};
  end

  // Cursor address: loaded by parameters, stepped on each buffered byte
  // Slots and a memory push never meet: they need different parser states
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cursor_address_low  <= `LCDCI_RST_BYTE;
      cursor_address_high <= `LCDCI_RST_BYTE;
    end else if (addr_lo_par) begin
      cursor_address_low <= host_data;
    end else if (addr_hi_par) begin
      cursor_address_high <= host_data;
    end else if (mem_push) begin
      cursor_address_low  <= next_cursor_addr[7:0];
      cursor_address_high <= next_cursor_addr[15:8];
    end
  end

endmodule : lcdci_top
